// [verilog/gpio_ports_pkg.sv]
package gpio_ports_pkg;

  localparam int unsigned PA_WIDTH = 7;
  localparam int unsigned PB_WIDTH = 8;
  localparam int unsigned PC_WIDTH = 5;

  // printed offsets are register indices; byte address is four times
  localparam logic [11:0] IDX_PORT_A_DATA      = 12'h000;
  localparam logic [11:0] IDX_PORT_B_DATA      = 12'h001;
  localparam logic [11:0] IDX_PORT_C_DATA      = 12'h002;
  localparam logic [11:0] IDX_PORT_A_DIRECTION = 12'h004;
  localparam logic [11:0] IDX_PORT_B_DIRECTION = 12'h005;
  localparam logic [11:0] IDX_PORT_C_DIRECTION = 12'h006;
  localparam logic [11:0] IDX_PIN_MUX_CONTROL  = 12'h008;

  localparam int unsigned ADDR_LSB      = 2;
  localparam int unsigned CLKOUT_BIT    = 7;
  localparam int unsigned CLKOUT_PIN    = 2;
  localparam int unsigned SHARED_LO_PIN = 6;
  localparam int unsigned SHARED_HI_PIN = 7;

  localparam logic [7:0] DIR_RESET = 8'h00;

endpackage

// [verilog/parallel_io_ports.sv]
// What this block does
// [RULE1] port a: seven pins, each with a latch bit and direction bit
// [RULE2] port b: eight pins with latch and direction, shared with converter and timer
// [RULE3] port c: five pins, each with latch bit and direction bit
// [RULE4] reset leaves data latches unchanged; only direction registers reset (code also clears the pin mux timer enables)
// [RULE5] direction 1 drives latch onto pin; 0 leaves pin as input
// [RULE6] reset clears all direction bits, all pins become inputs
// [RULE7] data read returns latch for bits whose direction is 1
// [RULE8] data read returns sampled pin level for bits whose direction is 0
// [RULE9] data writes always update the latch, regardless of direction
// [RULE10] port a, b, c data registers sit at indices 0, 1, 2
// [RULE11] port c direction bit 7 routes bus clock out on port c pin 2
// [RULE12] with clock out enabled, pin 2 driven by clock; its data bit reads 0
// [RULE13] reset clears clock-out enable with port c direction bits
// [RULE14] on port b pins 6 and 7 converter beats timer
// [RULE15] converter selecting a timer pin connects converter, disconnects timer
// [RULE16] software should disable timer channel before converter use of pin
// [RULE17] software should write latch before turning direction from 0 to 1
// [RULE18] accesses complete in one bus access; direction acts from next edge
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module parallel_io_ports
  import gpio_ports_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [13:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [PA_WIDTH-1:0]   portAIn,
  output logic      [PA_WIDTH-1:0]   portAOut,
  output logic      [PA_WIDTH-1:0]   portAOe,
  input  wire logic [PB_WIDTH-1:0]   portBIn,
  output logic      [PB_WIDTH-1:0]   portBOut,
  output logic      [PB_WIDTH-1:0]   portBOe,
  input  wire logic [PC_WIDTH-1:0]   portCIn,
  output logic      [PC_WIDTH-1:0]   portCOut,
  output logic      [PC_WIDTH-1:0]   portCOe,
  input  wire logic [PB_WIDTH-1:0]   adcSelect,
  input  wire logic [1:0]            timerOe,
  input  wire logic [1:0]            timerOut,
  output logic      [1:0]            timerIn,
  output logic      [PB_WIDTH-1:0]   adcIn
);

  typedef struct packed {
    logic [PA_WIDTH-1:0] latchA;
    logic [PB_WIDTH-1:0] latchB;
    logic [PC_WIDTH-1:0] latchC;
    logic [PA_WIDTH-1:0] dirA;
    logic [PB_WIDTH-1:0] dirB;
    logic [PC_WIDTH-1:0] dirC;
    logic                clkOutEn;
    logic [1:0]          timerEn;
    logic                busClk;
    logic [31:0]         rdata;
  } state_t;

  state_t stQ;
  state_t stD;
  state_t stR;

  logic        setupPhase;
  logic        wrAccess;
  logic [11:0] regIdx;
  logic        mapped;
  logic [31:0] rdVal;
  logic [PC_WIDTH-1:0] portCRd;

  assign setupPhase = psel && !penable;
  assign wrAccess   = psel && penable && pwrite;
  assign regIdx     = paddr[13:ADDR_LSB];

  always_comb begin
    mapped = 1'b1;
    if (regIdx == IDX_PORT_A_DATA || regIdx == IDX_PORT_B_DATA || regIdx == IDX_PORT_C_DATA) begin // [RULE10]
      mapped = 1'b1;
    end else if (regIdx == IDX_PORT_A_DIRECTION || regIdx == IDX_PORT_B_DIRECTION) begin
      mapped = 1'b1;
    end else if (regIdx == IDX_PORT_C_DIRECTION || regIdx == IDX_PIN_MUX_CONTROL) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // per-bit mux of latch vs pin; generate keeps widths independent
  logic [PA_WIDTH-1:0] portARd;
  logic [PB_WIDTH-1:0] portBRd;
  genvar gi;
  generate
    for (gi = 0; gi < PA_WIDTH; gi++) begin : g_rd_a
      assign portARd[gi] = stQ.dirA[gi] ? stQ.latchA[gi] : portAIn[gi]; // [RULE7] [RULE8]
    end
    for (gi = 0; gi < PB_WIDTH; gi++) begin : g_rd_b
      assign portBRd[gi] = stQ.dirB[gi] ? stQ.latchB[gi] : portBIn[gi]; // [RULE7] [RULE8]
    end
    for (gi = 0; gi < PC_WIDTH; gi++) begin : g_rd_c
      if (gi == CLKOUT_PIN) begin : g_clk
        assign portCRd[gi] = stQ.clkOutEn ? 1'b0 : (stQ.dirC[gi] ? stQ.latchC[gi] : portCIn[gi]); // [RULE12]
      end else begin : g_plain
        assign portCRd[gi] = stQ.dirC[gi] ? stQ.latchC[gi] : portCIn[gi]; // [RULE7] [RULE8]
      end
    end
  endgenerate

  always_comb begin
    rdVal = 32'h0000_0000;
    if (regIdx == IDX_PORT_A_DATA) begin
      rdVal[PA_WIDTH-1:0] = portARd;
    end else if (regIdx == IDX_PORT_B_DATA) begin
      rdVal[PB_WIDTH-1:0] = portBRd;
    end else if (regIdx == IDX_PORT_C_DATA) begin
      rdVal[PC_WIDTH-1:0] = portCRd;
    end else if (regIdx == IDX_PORT_A_DIRECTION) begin
      rdVal[PA_WIDTH-1:0] = stQ.dirA;
    end else if (regIdx == IDX_PORT_B_DIRECTION) begin
      rdVal[PB_WIDTH-1:0] = stQ.dirB;
    end else if (regIdx == IDX_PORT_C_DIRECTION) begin
      rdVal[PC_WIDTH-1:0] = stQ.dirC;
      rdVal[CLKOUT_BIT]   = stQ.clkOutEn; // [RULE11]
    end else if (regIdx == IDX_PIN_MUX_CONTROL) begin
      rdVal[1:0] = stQ.timerEn;
    end else begin
      rdVal = 32'h0000_0000;
    end
  end

  always_comb begin
    stD = stQ;
    // bus clock at half mclk rate, the fastest an flop-driven pin can toggle
    stD.busClk = ~stQ.busClk;
    // sample read data in setup so access phase answers at once
    if (setupPhase && !pwrite) begin
      stD.rdata = mapped ? rdVal : 32'h0000_0000; // [RULE18]
    end
    if (wrAccess) begin
      if (regIdx == IDX_PORT_A_DATA) begin
        stD.latchA = pwdata[PA_WIDTH-1:0]; // [RULE1] [RULE9]
      end else if (regIdx == IDX_PORT_B_DATA) begin
        stD.latchB = pwdata[PB_WIDTH-1:0]; // [RULE2] [RULE9]
      end else if (regIdx == IDX_PORT_C_DATA) begin
        stD.latchC = pwdata[PC_WIDTH-1:0]; // [RULE3] [RULE9]
      end else if (regIdx == IDX_PORT_A_DIRECTION) begin
        stD.dirA = pwdata[PA_WIDTH-1:0];
      end else if (regIdx == IDX_PORT_B_DIRECTION) begin
        stD.dirB = pwdata[PB_WIDTH-1:0];
      end else if (regIdx == IDX_PORT_C_DIRECTION) begin
        stD.dirC     = pwdata[PC_WIDTH-1:0];
        stD.clkOutEn = pwdata[CLKOUT_BIT]; // [RULE11]
      end else if (regIdx == IDX_PIN_MUX_CONTROL) begin
        stD.timerEn = pwdata[1:0];
      end
    end
  end

  // reset value: latches keep their contents unless written; direction, enables, bus clock and read data clear
  always_comb begin
    stR          = stD; // [RULE4]
    stR.dirA     = DIR_RESET[PA_WIDTH-1:0]; // [RULE6]
    stR.dirB     = DIR_RESET[PB_WIDTH-1:0]; // [RULE6]
    stR.dirC     = DIR_RESET[PC_WIDTH-1:0]; // [RULE6] [RULE13]
    stR.clkOutEn = 1'b0; // [RULE13]
    stR.timerEn  = 2'b00;
    stR.busClk   = 1'b0;
    stR.rdata    = 32'h0000_0000;
  end

  // synchronous reset, so holding latches is legal here
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stQ <= stR;
    end else begin
      stQ <= stD; // [RULE18]
    end
  end

  assign prdata  = stQ.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // pin drivers; latches come from flops, direction acts the edge after write
  logic [1:0] sharedHasTimer;
  always_comb begin
    portAOut = stQ.latchA;
    portAOe  = stQ.dirA; // [RULE5]
    portBOut = stQ.latchB;
    portBOe  = stQ.dirB; // [RULE5]
    sharedHasTimer = stQ.timerEn & ~{adcSelect[SHARED_HI_PIN], adcSelect[SHARED_LO_PIN]}; // [RULE14] [RULE15]
    if (sharedHasTimer[0] && timerOe[0]) begin
      portBOut[SHARED_LO_PIN] = timerOut[0];
      portBOe[SHARED_LO_PIN]  = 1'b1;
    end
    if (sharedHasTimer[1] && timerOe[1]) begin
      portBOut[SHARED_HI_PIN] = timerOut[1];
      portBOe[SHARED_HI_PIN]  = 1'b1;
    end
    // converter owns the pin: buffer off so analog input is undisturbed
    if (adcSelect[SHARED_LO_PIN]) begin
      portBOe[SHARED_LO_PIN] = 1'b0; // [RULE14]
    end
    if (adcSelect[SHARED_HI_PIN]) begin
      portBOe[SHARED_HI_PIN] = 1'b0; // [RULE14]
    end
    timerIn[0] = sharedHasTimer[0] ? portBIn[SHARED_LO_PIN] : 1'b0; // [RULE15]
    timerIn[1] = sharedHasTimer[1] ? portBIn[SHARED_HI_PIN] : 1'b0; // [RULE15]
    adcIn    = portBIn & adcSelect;
    portCOut = stQ.latchC;
    portCOe  = stQ.dirC; // [RULE5]
    if (stQ.clkOutEn) begin
      portCOut[CLKOUT_PIN] = stQ.busClk; // [RULE12]
      portCOe[CLKOUT_PIN]  = 1'b1; // [RULE11]
    end
  end

  // reset clears control only; latches ride through, unknown until written
  AST_DIR_RESET: assert property (@(posedge mclk) // [RULE6]
      !reset_n |=> (portAOe == '0 && portCOe == '0))
    else $error("direction not cleared by reset");
  AST_DIR_RESET_B: assert property (@(posedge mclk) // [RULE6]
      !reset_n |=> portBOe == '0)
    else $error("port b direction not cleared by reset");
  AST_CLK_RESET: assert property (@(posedge mclk) // [RULE13]
      !reset_n |=> !stQ.clkOutEn)
    else $error("clock out enable not cleared by reset");
  AST_LATCH_HOLD: assert property (@(posedge mclk) // [RULE4]
      (!reset_n && !wrAccess) |=> stQ.latchA === $past(stQ.latchA))
    else $error("reset disturbed port a latch");
  AST_LATCH_HOLD_B: assert property (@(posedge mclk) // [RULE4]
      (!reset_n && !wrAccess) |=> stQ.latchB === $past(stQ.latchB))
    else $error("reset disturbed port b latch");
  AST_LATCH_HOLD_C: assert property (@(posedge mclk) // [RULE4]
      (!reset_n && !wrAccess) |=> stQ.latchC === $past(stQ.latchC))
    else $error("reset disturbed port c latch");
  AST_BUSCLK_RESET: assert property (@(posedge mclk) // [RULE13]
      !reset_n |=> !portCOe[CLKOUT_PIN])
    else $error("clock pin still driven after reset");

  // register writes land at the access edge
  AST_WRITE_A: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE9]
      (wrAccess && regIdx == IDX_PORT_A_DATA) |=> portAOut == $past(pwdata[PA_WIDTH-1:0]))
    else $error("port a latch write lost");
  AST_WRITE_B: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2] [RULE9]
      (wrAccess && regIdx == IDX_PORT_B_DATA) |=> stQ.latchB == $past(pwdata[PB_WIDTH-1:0]))
    else $error("port b latch write lost");
  AST_WRITE_C: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE3] [RULE9]
      (wrAccess && regIdx == IDX_PORT_C_DATA) |=> stQ.latchC == $past(pwdata[PC_WIDTH-1:0]))
    else $error("port c latch write lost");
  AST_WRITE_INPUT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE9]
      (wrAccess && regIdx == IDX_PORT_A_DATA && stQ.dirA == '0) |=> portAOe == '0)
    else $error("write to input pin drove it");
  AST_DIR_NEXT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE18]
      (wrAccess && regIdx == IDX_PORT_A_DIRECTION) |=> portAOe == $past(pwdata[PA_WIDTH-1:0]))
    else $error("direction write not on pin next edge");
  AST_DIR_NEXT_B: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE18]
      (wrAccess && regIdx == IDX_PORT_B_DIRECTION) |=> stQ.dirB == $past(pwdata[PB_WIDTH-1:0]))
    else $error("port b direction write lost");
  AST_DIR_NEXT_C: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE11]
      (wrAccess && regIdx == IDX_PORT_C_DIRECTION) |=>
      (stQ.dirC == $past(pwdata[PC_WIDTH-1:0]) && stQ.clkOutEn == $past(pwdata[CLKOUT_BIT])))
    else $error("port c direction write lost");
  AST_UNMAPPED_WR: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE10]
      (wrAccess && !mapped) |=>
      (stQ.dirA == $past(stQ.dirA) && stQ.dirB == $past(stQ.dirB) && stQ.dirC == $past(stQ.dirC)))
    else $error("unmapped write changed a register");

  // pin buffers follow the registers
  AST_OE_FOLLOW: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
      (stQ.dirA[0] && !portAOe[0]) == 1'b0)
    else $error("output buffer off while direction set");
  AST_OE_A: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
      portAOe == stQ.dirA)
    else $error("port a buffer not per direction");
  AST_OUT_A: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
      portAOut === stQ.latchA)
    else $error("port a pin not latch");
  AST_OE_B: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
      portBOe[SHARED_LO_PIN-1:0] == stQ.dirB[SHARED_LO_PIN-1:0])
    else $error("port b buffer not per direction");
  AST_OUT_B: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
      portBOut[SHARED_LO_PIN-1:0] === stQ.latchB[SHARED_LO_PIN-1:0])
    else $error("port b pin not latch");
  AST_OE_C: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
      !stQ.clkOutEn |-> portCOe == stQ.dirC)
    else $error("port c buffer not per direction");
  AST_OUT_C: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
      !stQ.clkOutEn |-> portCOut === stQ.latchC)
    else $error("port c pin not latch");

  // read data: latch for outputs, pin for inputs
  AST_RD_INPUT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE8]
      (setupPhase && !pwrite && regIdx == IDX_PORT_A_DATA && stQ.dirA == '0)
      |=> prdata[PA_WIDTH-1:0] == $past(portAIn))
    else $error("input read not pin level");
  AST_RD_OUTPUT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
      (setupPhase && !pwrite && regIdx == IDX_PORT_B_DATA && stQ.dirB == '1)
      |=> prdata[PB_WIDTH-1:0] == $past(stQ.latchB))
    else $error("output read not latch");
  AST_RD_A_OUT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
      (setupPhase && !pwrite && regIdx == IDX_PORT_A_DATA && stQ.dirA == '1)
      |=> prdata[PA_WIDTH-1:0] === $past(stQ.latchA))
    else $error("port a output read not latch");
  AST_RD_B_IN: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE8]
      (setupPhase && !pwrite && regIdx == IDX_PORT_B_DATA && stQ.dirB == '0)
      |=> prdata[PB_WIDTH-1:0] == $past(portBIn))
    else $error("port b input read not pin");
  AST_RD_C_OUT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
      (setupPhase && !pwrite && regIdx == IDX_PORT_C_DATA && stQ.dirC == '1 && !stQ.clkOutEn)
      |=> prdata[PC_WIDTH-1:0] === $past(stQ.latchC))
    else $error("port c output read not latch");
  AST_PIN2_READ: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE8]
      (setupPhase && !pwrite && regIdx == IDX_PORT_C_DATA && !stQ.dirC[CLKOUT_PIN] && !stQ.clkOutEn)
      |=> prdata[CLKOUT_PIN] == $past(portCIn[CLKOUT_PIN]))
    else $error("port c pin 2 input read wrong");
  AST_RD_DIR_A: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE1]
      (setupPhase && !pwrite && regIdx == IDX_PORT_A_DIRECTION)
      |=> prdata[PA_WIDTH-1:0] == $past(stQ.dirA))
    else $error("port a direction read wrong");
  AST_RD_DIR_B: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
      (setupPhase && !pwrite && regIdx == IDX_PORT_B_DIRECTION)
      |=> prdata[PB_WIDTH-1:0] == $past(stQ.dirB))
    else $error("port b direction read wrong");
  AST_RD_DIR_C: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE11]
      (setupPhase && !pwrite && regIdx == IDX_PORT_C_DIRECTION)
      |=> (prdata[PC_WIDTH-1:0] == $past(stQ.dirC) && prdata[CLKOUT_BIT] == $past(stQ.clkOutEn)))
    else $error("port c direction read wrong");
  AST_RD_UPPER: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE18]
      prdata[31:PB_WIDTH] == '0)
    else $error("unused read bits not zero");

  // bus answers in one access, error only on unmapped access
  AST_READY: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE18]
      pready)
    else $error("wait state inserted");
  AST_SETUP_NO_ERR: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE18]
      setupPhase |-> !pslverr)
    else $error("error flagged in setup");
  AST_MAP_DATA: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE10]
      (psel && penable && regIdx <= IDX_PORT_C_DATA) |-> !pslverr)
    else $error("data register refused");
  AST_UNMAPPED_ERR: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE10]
      (psel && penable && !mapped) |-> pslverr)
    else $error("unmapped access not refused");

  // clock output on port c pin 2
  AST_CLK_TOGGLE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE11]
      (stQ.clkOutEn && $past(stQ.clkOutEn)) |-> portCOut[CLKOUT_PIN] != $past(portCOut[CLKOUT_PIN]))
    else $error("clock output not toggling");
  AST_CLK_DRIVE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE12]
      stQ.clkOutEn |-> (portCOe[CLKOUT_PIN] && portCOut[CLKOUT_PIN] == stQ.busClk))
    else $error("clock pin not driven by clock");
  AST_CLK_RELEASE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE11]
      (!stQ.clkOutEn && !stQ.dirC[CLKOUT_PIN]) |-> !portCOe[CLKOUT_PIN])
    else $error("clock pin not released");
  AST_CLK_RDZERO: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE12]
      (setupPhase && !pwrite && regIdx == IDX_PORT_C_DATA && stQ.clkOutEn) |=> !prdata[CLKOUT_PIN])
    else $error("clock pin data bit not zero");

  // shared port b pins: converter first, then timer
  AST_ADC_PRIO: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE14] [RULE15]
      adcSelect[SHARED_HI_PIN] |-> (!portBOe[SHARED_HI_PIN] && timerIn[1] == 1'b0))
    else $error("timer kept shared pin under converter");
  AST_ADC_LO: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE14] [RULE15]
      adcSelect[SHARED_LO_PIN] |-> (!portBOe[SHARED_LO_PIN] && timerIn[0] == 1'b0))
    else $error("timer kept low shared pin");
  AST_TIMER_LO: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
      (stQ.timerEn[0] && !adcSelect[SHARED_LO_PIN] && timerOe[0]) |-> (portBOe[SHARED_LO_PIN] && portBOut[SHARED_LO_PIN] == timerOut[0]))
    else $error("timer not driving low shared pin");
  AST_TIMER_HI: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
      (stQ.timerEn[1] && !adcSelect[SHARED_HI_PIN] && timerOe[1]) |-> (portBOe[SHARED_HI_PIN] && portBOut[SHARED_HI_PIN] == timerOut[1]))
    else $error("timer not driving high shared pin");
  AST_TIMER_IN_LO: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
      (stQ.timerEn[0] && !adcSelect[SHARED_LO_PIN]) |-> timerIn[0] == portBIn[SHARED_LO_PIN])
    else $error("timer not seeing low shared pin");
  AST_TIMER_IN_HI: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
      (stQ.timerEn[1] && !adcSelect[SHARED_HI_PIN]) |-> timerIn[1] == portBIn[SHARED_HI_PIN])
    else $error("timer not seeing high shared pin");
  AST_ADC_IN: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE15]
      adcIn == (portBIn & adcSelect))
    else $error("converter input not per selection");

endmodule // parallel_io_ports

// [tb/pin_world.sv]
`timescale 1ns/10ps
module pin_world
  import gpio_ports_pkg::*;
(
  input  wire logic [PA_WIDTH-1:0] aOut,
  input  wire logic [PA_WIDTH-1:0] aOe,
  input  wire logic [PA_WIDTH-1:0] extA,
  output logic      [PA_WIDTH-1:0] aIn,
  input  wire logic [PB_WIDTH-1:0] bOut,
  input  wire logic [PB_WIDTH-1:0] bOe,
  input  wire logic [PB_WIDTH-1:0] extB,
  output logic      [PB_WIDTH-1:0] bIn,
  input  wire logic [PC_WIDTH-1:0] cOut,
  input  wire logic [PC_WIDTH-1:0] cOe,
  input  wire logic [PC_WIDTH-1:0] extC,
  output logic      [PC_WIDTH-1:0] cIn
);
  // driven bits show the chip, released bits the outside world
  assign aIn = (aOut & aOe) | (extA & ~aOe);
  assign bIn = (bOut & bOe) | (extB & ~bOe);
  assign cIn = (cOut & cOe) | (extC & ~cOe);
endmodule // pin_world

// [tb/parallel_io_ports_abc_bench.sv]
`timescale 1ns/10ps
module parallel_io_ports_abc_bench;
  import gpio_ports_pkg::*;
  logic                mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [13:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic [PA_WIDTH-1:0] aOut, aOe, aIn, extA;
  logic [PB_WIDTH-1:0] bOut, bOe, bIn, extB, adcSelect, adcIn;
  logic [PC_WIDTH-1:0] cOut, cOe, cIn, extC;
  logic [1:0]          timerOe, timerOut, timerIn;
  int                  errTotal, nCompared;

  parallel_io_ports i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .portAIn(aIn),
    .portAOut(aOut), .portAOe(aOe), .portBIn(bIn), .portBOut(bOut), .portBOe(bOe), .portCIn(cIn),
    .portCOut(cOut), .portCOe(cOe), .adcSelect(adcSelect), .timerOe(timerOe), .timerOut(timerOut),
    .timerIn(timerIn), .adcIn(adcIn));
  pin_world i_pins (.aOut(aOut), .aOe(aOe), .extA(extA), .aIn(aIn), .bOut(bOut), .bOe(bOe), .extB(extB),
    .bIn(bIn), .cOut(cOut), .cOe(cOe), .extC(extC), .cIn(cIn));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // pready is sampled, never assumed: the wait is bounded
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk(0, 1, "apb timeout");
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic do_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
  endtask

  function automatic logic [7:0] msk(int p);
    return p == 0 ? 8'h7f : p == 1 ? 8'hff : 8'h1f;
  endfunction

  function automatic logic [31:0] pinsOf(int p);
    return p == 0 ? {8'(aOe), 8'(aOut)} : p == 1 ? {bOe, bOut} : {8'(cOe), 8'(cOut)};
  endfunction

  task automatic t_reset;
    do_reset();
    @(posedge mclk);
    #1;
    chk({aOe, bOe, cOe}, 0, "oe after reset");
    for (int p = 0; p < 3; p++) rdchk(IDX_PORT_A_DIRECTION + 12'(p), 0, "dir reset");
    $display("test reset done");
  endtask

  task automatic t_ports;
    logic [7:0] e;
    for (int p = 0; p < 3; p++) begin
      e = p == 0 ? 8'(extA) : p == 1 ? extB : 8'(extC);
      apb(1'b1, IDX_PORT_A_DATA + 12'(p), 32'ha5);
      chk(pinsOf(p) >> 8, 0, "input pin undriven");
      rdchk(IDX_PORT_A_DATA + 12'(p), e & msk(p), "read pins");
      apb(1'b1, IDX_PORT_A_DIRECTION + 12'(p), msk(p) & 8'h0f);
      rdchk(IDX_PORT_A_DATA + 12'(p), ((8'ha5 & 8'h0f) | (e & 8'hf0)) & msk(p), "mixed");
      apb(1'b1, IDX_PORT_A_DIRECTION + 12'(p), msk(p));
      chk(pinsOf(p), {msk(p), 8'ha5 & msk(p)}, "pins driven");
      rdchk(IDX_PORT_A_DIRECTION + 12'(p), msk(p), "dir width");
      rdchk(IDX_PORT_A_DATA + 12'(p), 8'ha5 & msk(p), "read latch");
      apb(1'b1, IDX_PORT_A_DIRECTION + 12'(p), 0);
    end
    $display("test ports done");
  endtask

  task automatic t_keep;
    apb(1'b1, IDX_PORT_A_DATA, 32'h33);
    do_reset();
    @(posedge mclk);
    apb(1'b1, IDX_PORT_A_DIRECTION, 32'h7f);
    chk(aOut, 7'h33, "latch kept pin");
    rdchk(IDX_PORT_A_DATA, 32'h33, "latch kept");
    $display("test keep done");
  endtask

  task automatic t_clock;
    logic v;
    apb(1'b1, IDX_PORT_C_DATA, 32'h1f);
    // pin 2 direction left clear: the clock must drive it anyway
    apb(1'b1, IDX_PORT_C_DIRECTION, 32'h80);
    v = cOut[2];
    chk(cOe, 5'h04, "clock pin driven");
    @(posedge mclk);
    #1;
    chk(cOut[2] ^ v, 1, "clock toggles");
    rdchk(IDX_PORT_C_DATA, extC & 5'h1b, "clock bit reads 0");
    rdchk(IDX_PORT_C_DIRECTION, 32'h80, "enable reads back");
    do_reset();
    @(posedge mclk);
    #1;
    chk(cOe, 0, "clock released");
    rdchk(IDX_PORT_C_DIRECTION, 0, "enable cleared");
    $display("test clock done");
  endtask

  task automatic t_shared;
    apb(1'b1, IDX_PIN_MUX_CONTROL, 32'h3);
    @(posedge mclk);
    timerOe <= 2'b11;
    timerOut <= 2'b01;
    @(posedge mclk);
    #1;
    chk({bOe[7:6], bOut[7:6], timerIn}, 6'b110101, "timer owns pins");
    // converter grabs the pins while the timer is still on
    @(posedge mclk);
    adcSelect <= 8'hc0;
    @(posedge mclk);
    #1;
    chk({bOe[7:6], timerIn}, 0, "timer cut off");
    chk(adcIn, extB & 8'hc0, "converter sees pins");
    @(posedge mclk);
    timerOe <= 2'b00;
    adcSelect <= 8'h00;
    // recommended order: timer channel off before the converter takes the pin
    apb(1'b1, IDX_PIN_MUX_CONTROL, 32'h0);
    @(posedge mclk);
    adcSelect <= 8'hc0;
    @(posedge mclk);
    #1;
    chk({bOe[7:6], adcIn}, {2'b00, extB & 8'hc0}, "converter after timer off");
    @(posedge mclk);
    adcSelect <= 8'h00;
    $display("test shared done");
  endtask

  task automatic t_unmapped;
    rdchk(12'h009, 0, "unmapped read");
    chk(err, 1, "unmapped error");
    apb(1'b1, 12'h009, 32'hff);
    chk(err, 1, "unmapped write error");
    rdchk(IDX_PORT_A_DIRECTION, 0, "unmapped write ignored");
    $display("test unmapped done");
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0;
    extA = 7'h2c;
    extB = 8'hbc;
    extC = 5'h13;
    adcSelect = 8'h00;
    timerOe = 2'b00;
    timerOut = 2'b00;
    errTotal = 0;
    nCompared = 0;
    t_reset();
    t_ports();
    t_keep();
    t_clock();
    t_shared();
    t_unmapped();
    tally_and_finish();
  end
endmodule // parallel_io_ports_abc_bench
